// [core_mem_pkg.sv]
// Constants shared by the core memory data path and protection control.
package core_mem_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam int PAIRS  = 6;

  // ---------------------------------------------------------------------------
  // Timing of one delay-line pass
  // ---------------------------------------------------------------------------
  localparam int CLK_NS   = 100;
  localparam int HALF_NS  = 500;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS   = 100;
  localparam int GAP_CYC  = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] DRV_ON   = 3'h1;
  localparam logic [2:0] STROBE_T = 3'h2;
  localparam logic [2:0] CLR_T    = 3'h3;
  localparam logic [2:0] DRV_OFF  = 3'h4;
  localparam logic [2:0] LAST_T   = 3'(HALF_CYC - 1);
  localparam logic [1:0] GAP_LAST = 2'(GAP_CYC - 1);

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] INFO_OFS   = 4'h8;
  localparam logic [3:0] COUNT_OFS  = 4'hc;
  localparam int CTRL_PORT_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Cycle sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_READ,
    ST_GAP,
    ST_WRITE,
    ST_RELEASE
  } cyc_state_t;

endpackage

// [core_memory_data_path_control.sv]
// Data path, cycle timing and protection control for a core memory bank.
`timescale 1ns/1ns
// Function
// RULE_01: Mode signal picks restore or new data.
// RULE_02: Read mode strobes 17 bits into register.
// RULE_03: Read mode restores register word on write.
// RULE_04: Write mode blocks cores, writes user bits.
// RULE_05: Register clears late on mode/gate change.
// RULE_06: Lagging parity bit has its own path.
// RULE_07: Core parity out, user parity in separately.
// RULE_08: Fourteen parallel address bits select location.
// RULE_09: Separate 17-bit input and output data groups.
// RULE_10: Address and data held stable all cycle.
// RULE_11: Inhibit blocks Y current for zero.
// RULE_12: Twelve timing lines gate address-selected predrives.
// RULE_13: Sense data valid only at strobes.
// RULE_14: Airflow failure shuts down unless disabled.
// RULE_15: Voltage failure disables predrive, flags status.
// RULE_16: Status true when both monitors true.
// RULE_17: Pair pulses never overlap, keep gap.
// RULE_18: Missing module or lost timing forces off.
// RULE_19: Predrive disable blocks access on faults.
// RULE_20: Strobe enables fire selected and common strobes.
// RULE_21: Cycle starts on clock B after address.
// RULE_22: Two passes: read half then write half.
// RULE_23: User data and parity taken under gate.
// RULE_24: User parity present before write half.
module core_memory_data_path_control
  import core_mem_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave.
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [3:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // Port user side.
  input  wire logic                mem_req_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic                read_mode_i,
  input  wire logic                port_connect_gate_i,
  input  wire logic                clk_b_i,
  input  wire logic                reset_early_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wpar_i,
  output logic      [DATA_W-1:0]   rdata_o,
  output logic                     rpar_o,
  output logic                     addr_here_o,
  output logic                     req_release_o,
  // Core storage unit side.
  input  wire logic [DATA_W-1:0]   core_rdata_i,
  input  wire logic                core_rpar_i,
  output logic      [ADDR_W-1:0]   core_addr_o,
  output logic      [DATA_W-1:0]   core_wdata_o,
  output logic                     core_wpar_o,
  output logic      [2*PAIRS-1:0]  drive_timing_o,
  output logic      [1:0]          strobe_enable_o,
  output logic      [3:0]          preamp_select_o,
  output logic                     sense_strobe_o,
  // Monitors and protection.
  input  wire logic                airflow_fail_i,
  input  wire logic                voltage_fail_i,
  input  wire logic                mem_disable_i,
  input  wire logic                ancillary_present_i,
  output logic                     power_shutdown_o,
  output logic                     predrive_disable_o,
  output logic                     mem_status_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  cyc_state_t             state_q;
  logic [2:0]             tick_q;
  logic [1:0]             gap_q;
  logic [31:0]            ctrl_q;
  logic [15:0]            count_q;
  logic [ADDR_W-1:0]      addr_q;
  logic                   mode_q;
  logic [DATA_W:0]        info_q;
  logic                   mode_seen_q;
  logic                   gate_seen_q;
  logic                   inhibit;
  logic                   change;
  logic                   drive_win;
  logic [2*PAIRS-1:0]     drv_d;
  logic [1:0]             xsel;
  logic                   wb_req;

  // Any fault or missing module stops every access.
  assign inhibit   = predrive_disable_o | ~ancillary_present_i; // [RULE_19]
  assign change    = (read_mode_i != mode_seen_q) |
                     (port_connect_gate_i != gate_seen_q);
  assign drive_win = (tick_q >= DRV_ON) && (tick_q < DRV_OFF);
  assign xsel      = (addr_q[1:0] == 2'h3) ? 2'h2 : addr_q[1:0];
  assign wb_req    = cyc_i & stb_i & ~ack_o;

  // ---------------------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------------------
  // Two delay-line passes run back to back with a guard gap between them.
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_early_i || inhibit) begin
      state_q <= ST_IDLE; // Lost or blocked cycles end safely. [RULE_18]
      tick_q  <= 3'h0;
      gap_q   <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (mem_req_i && ctrl_q[CTRL_PORT_EN]) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (clk_b_i) begin
            state_q <= ST_READ; // [RULE_21]
            tick_q  <= 3'h0;
          end
        end
        ST_READ: begin
          if (tick_q == LAST_T) begin
            state_q <= ST_GAP; // [RULE_22]
            gap_q   <= 2'h0;
          end else begin
            tick_q <= tick_q + 3'h1;
          end
        end
        ST_GAP: begin
          if (gap_q == GAP_LAST) begin
            state_q <= ST_WRITE; // [RULE_22]
            tick_q  <= 3'h0;
          end else begin
            gap_q <= gap_q + 2'h1;
          end
        end
        ST_WRITE: begin
          if (tick_q == LAST_T) begin
            state_q <= ST_RELEASE;
          end else begin
            tick_q <= tick_q + 3'h1;
          end
        end
        ST_RELEASE: begin
          if (!mem_req_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Handshake flags towards the port user.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_here_o   <= 1'b0;
      req_release_o <= 1'b0;
    end else begin
      addr_here_o   <= (state_q != ST_IDLE) && !inhibit && !reset_early_i;
      req_release_o <= (state_q == ST_RELEASE) && !inhibit;
    end
  end

  // ---------------------------------------------------------------------------
  // Address and mode holding
  // ---------------------------------------------------------------------------
  // Address and mode are frozen when the cycle is armed and held throughout.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      mode_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      addr_q <= addr_i; // [RULE_08] [RULE_10]
      mode_q <= read_mode_i; // [RULE_01]
    end
  end

  // Registered copies of the address lines to the storage unit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_addr_o <= '0;
    end else begin
      core_addr_o <= addr_q; // [RULE_08]
    end
  end

  // ---------------------------------------------------------------------------
  // Information register
  // ---------------------------------------------------------------------------
  // Bit DATA_W is the parity bit; in write mode it is loaded on its own later path.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      info_q <= '0;
    end else if (state_q == ST_READ && tick_q == STROBE_T && mode_q) begin
      info_q <= {core_rpar_i, core_rdata_i}; // [RULE_02] [RULE_07] [RULE_13]
    end else if (state_q == ST_READ && !mode_q && port_connect_gate_i) begin
      info_q[DATA_W-1:0] <= wdata_i; // [RULE_04] [RULE_23]
    end else if (state_q == ST_GAP && !mode_q && port_connect_gate_i) begin
      info_q[DATA_W] <= wpar_i; // Lagging parity. [RULE_06] [RULE_24]
    end else if (change && (state_q == ST_RELEASE || state_q == ST_IDLE ||
                 (state_q == ST_WRITE && tick_q >= CLR_T))) begin
      info_q <= '0; // [RULE_05]
    end
  end

  // Last seen levels of the mode and gate lines for change detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_seen_q <= 1'b1; // Matches the read-mode idle level.
      gate_seen_q <= 1'b0;
    end else begin
      mode_seen_q <= read_mode_i;
      gate_seen_q <= port_connect_gate_i;
    end
  end

  // Read word to the user, and the write lines through the inhibits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o      <= '0;
      rpar_o       <= 1'b0;
      core_wdata_o <= '0;
      core_wpar_o  <= 1'b0;
    end else begin
      rdata_o <= info_q[DATA_W-1:0]; // [RULE_09]
      rpar_o  <= info_q[DATA_W]; // [RULE_07]
      if (state_q == ST_WRITE && !inhibit) begin
        core_wdata_o <= info_q[DATA_W-1:0]; // One lets Y current. [RULE_11]
        core_wpar_o  <= info_q[DATA_W]; // [RULE_03] [RULE_07]
      end else begin
        core_wdata_o <= '0;
        core_wpar_o  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Driveline timing and protection latches
  // ---------------------------------------------------------------------------
  // Pairs 0-2 are X lines, 3-5 are Y lines; read drives pos, write drives neg.
  generate
    for (genvar k = 0; k < PAIRS; k++) begin : g_pair
      logic sel;
      if (k < 3) begin : g_x
        assign sel = (xsel == 2'(k));
      end else begin : g_y
        assign sel = (addr_q[2] == 1'(k - 3)) || (k == 5);
      end
      // A pulse may start only if its partner was off last cycle.
      assign drv_d[2*k]   = sel && drive_win && state_q == ST_READ &&
                            !drive_timing_o[2*k+1] && !inhibit; // [RULE_17]
      assign drv_d[2*k+1] = sel && drive_win && state_q == ST_WRITE &&
                            !drive_timing_o[2*k] && !inhibit; // [RULE_17]
    end
  endgenerate

  // Timing outputs, all forced low while access is blocked.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_timing_o <= '0;
    end else begin
      drive_timing_o <= drv_d; // [RULE_12] [RULE_18]
    end
  end

  // Strobe enables, preamp select and the common sense strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_enable_o <= 2'h0;
      preamp_select_o <= 4'h0;
      sense_strobe_o  <= 1'b0;
    end else begin
      strobe_enable_o[0] <= state_q == ST_READ && tick_q == STROBE_T-3'h1 &&
                            !inhibit;
      strobe_enable_o[1] <= state_q == ST_READ && tick_q == STROBE_T-3'h1 &&
                            !inhibit;
      preamp_select_o <= strobe_enable_o[0] ?
                         4'(4'h1 << addr_q[1:0]) : 4'h0; // [RULE_20]
      sense_strobe_o  <= strobe_enable_o[1]; // [RULE_20]
    end
  end

  // ---------------------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------------------
  // Memory disable masks the airflow trip during power sequencing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_shutdown_o   <= 1'b0;
      predrive_disable_o <= 1'b1;
      mem_status_o       <= 1'b0;
    end else begin
      power_shutdown_o   <= airflow_fail_i & ~mem_disable_i; // [RULE_14]
      predrive_disable_o <= mem_disable_i | airflow_fail_i |
                            voltage_fail_i; // [RULE_15] [RULE_19]
      mem_status_o       <= voltage_fail_i & airflow_fail_i; // [RULE_16]
    end
  end

  // ---------------------------------------------------------------------------
  // Wishbone registers
  // ---------------------------------------------------------------------------
  // Control register write with byte lanes; ack for one cycle on any access.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      ack_o  <= 1'b0;
      dat_o  <= '0;
    end else begin
      ack_o <= wb_req;
      dat_o <= '0;
      if (wb_req && we_i && adr_i == CTRL_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) begin
            ctrl_q[8*b +: 8] <= dat_i[8*b +: 8];
          end
        end
      end
      if (wb_req && !we_i) begin
        case (adr_i)
          CTRL_OFS:   dat_o <= ctrl_q;
          STATUS_OFS: dat_o <= {24'h0, mem_status_o, power_shutdown_o,
                                predrive_disable_o, mode_q,
                                1'b0, 3'(state_q)};
          INFO_OFS:   dat_o <= {15'h0, info_q};
          COUNT_OFS:  dat_o <= {16'h0, count_q};
          default:    dat_o <= '0;
        endcase
      end
    end
  end

  // Count of completed memory cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 16'h0;
    end else if (state_q == ST_WRITE && tick_q == LAST_T && !inhibit) begin
      count_q <= count_q + 16'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_on_clkb: assert property ( // [RULE_21]
    state_q == ST_ARMED && clk_b_i && !reset_early_i && !inhibit
    |=> state_q == ST_READ && tick_q == 3'h0)
    else $error("Cycle did not start on clock B.");
  a_two_passes: assert property ( // [RULE_22]
    state_q == ST_READ && tick_q == LAST_T && !reset_early_i && !inhibit
    |=> state_q == ST_GAP ##1 state_q == ST_WRITE)
    else $error("Write pass did not follow read pass.");
  a_read_capture: assert property ( // [RULE_02]
    state_q == ST_READ && tick_q == STROBE_T && mode_q
    |=> info_q == $past({core_rpar_i, core_rdata_i}))
    else $error("Read word not captured at strobe.");
  a_restore_data: assert property ( // [RULE_03]
    state_q == ST_WRITE && !inhibit |=> core_wdata_o == $past(info_q[15:0]))
    else $error("Write lines do not carry register word.");
  a_no_overlap: assert property ( // [RULE_17]
    (drive_timing_o & (drive_timing_o >> 1) & 12'h555) == 12'h0)
    else $error("Pos and neg timing pulses overlap.");
  a_interlock_off: assert property ( // [RULE_18]
    !ancillary_present_i |=> drive_timing_o == 12'h0)
    else $error("Timing active without ancillary module.");
  a_addr_stable: assert property ( // [RULE_10]
    state_q inside {ST_READ, ST_GAP, ST_WRITE} && tick_q != 3'h0
    |-> $stable(core_addr_o))
    else $error("Storage address moved during a cycle.");
  a_predrive_block: assert property ( // [RULE_19]
    voltage_fail_i |=> predrive_disable_o ##1 drive_timing_o == 12'h0)
    else $error("Voltage failure did not block access.");
  a_airflow_mask: assert property ( // [RULE_14]
    airflow_fail_i && !mem_disable_i |=> power_shutdown_o)
    else $error("Airflow failure did not request shutdown.");
  a_status_both: assert property ( // [RULE_16]
    mem_status_o == $past(voltage_fail_i && airflow_fail_i))
    else $error("Status does not follow both monitors.");
  a_strobe_pair: assert property ( // [RULE_20]
    strobe_enable_o[1] |=> sense_strobe_o && preamp_select_o != 4'h0)
    else $error("Sense strobes not fired by enables.");

  c_read_cycle: cover property (
    state_q == ST_READ && mode_q ##[1:20] state_q == ST_RELEASE);
  c_write_cycle: cover property (
    state_q == ST_WRITE && !mode_q && core_wdata_o != 16'h0);
  c_early_reset: cover property (state_q == ST_READ && reset_early_i);

endmodule // core_memory_data_path_control

// [core_mem_models.sv]
// Port user and core array models for the data path control bench.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port user: requests, runs clock B and lags its parity bit.
// ----------------------------------------------------------------
module port_user_model (
  // Clock, reset and bench control.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [15:0] data_i,
  input  wire logic        par_i,
  // Answers from the memory.
  input  wire logic        addr_here_i,
  input  wire logic        release_i,
  // Lines to the memory.
  output logic             mem_req_o,
  output logic             clk_b_o,
  output logic [15:0]      wdata_o,
  output logic             wpar_o,
  output logic             done_o
);
  logic       rel_q;
  logic [1:0] lag_q;
  logic [1:0] cb_q;

  // Tracks the release and counts cycles since address here.
  always_ff @(posedge clk_i) begin
    if (rst_i || !go_i) begin
      rel_q <= 1'b0;
      lag_q <= 2'h0;
    end else begin
      if (release_i) begin
        rel_q <= 1'b1;
      end
      if (addr_here_i && lag_q != 2'h3) begin
        lag_q <= lag_q + 2'h1;
      end
    end
  end

  // Clock B pulses every third cycle whatever the memory does.
  always_ff @(posedge clk_i) begin
    cb_q <= (rst_i || cb_q == 2'h2) ? 2'h0 : cb_q + 2'h1;
  end

  // The request drops once the memory lets go of it.
  assign mem_req_o = go_i & ~rel_q;
  assign clk_b_o   = (cb_q == 2'h2);
  // Idle data lines carry the inverse pattern, not stale data.
  assign wdata_o   = go_i ? data_i : ~data_i;
  // Parity is only right two cycles after address here.
  assign wpar_o    = (lag_q >= 2'h2) ? par_i : ~par_i;
  assign done_o    = rel_q;
endmodule // port_user_model

// ----------------------------------------------------------------
// Core array: shows a word only under strobes, stores on write.
// ----------------------------------------------------------------
module core_array_model (
  // Clock.
  input  wire logic        clk_i,
  // Lines from the data path control.
  input  wire logic [13:0] core_addr_i,
  input  wire logic [15:0] core_wdata_i,
  input  wire logic        core_wpar_i,
  input  wire logic [11:0] drive_timing_i,
  input  wire logic [1:0]  strobe_enable_i,
  input  wire logic        sense_strobe_i,
  // Sensed word.
  output logic [15:0]      core_rdata_o,
  output logic             core_rpar_o
);
  logic [16:0] mem_q [16];
  logic [16:0] last_q;
  logic        sense;

  // Every location starts with the same known word.
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 17'h1a5c3;
    end
    last_q = 17'h00000;
  end

  // Outside strobes the lines show the inverse of the last word.
  assign sense = (|strobe_enable_i) | sense_strobe_i;
  assign {core_rpar_o, core_rdata_o} =
    sense ? mem_q[core_addr_i[3:0]] : ~last_q;

  // Write pass pulses store the word presented on the write lines.
  always @(posedge clk_i) begin
    if (sense) begin
      last_q <= mem_q[core_addr_i[3:0]];
    end
    if (|(drive_timing_i & 12'haaa)) begin
      mem_q[core_addr_i[3:0]] <= {core_wpar_i, core_wdata_i};
    end
  end
endmodule // core_array_model

// [core_memory_data_path_control_tb_top.sv]
// Self-checking bench for the core memory data path control.
`timescale 1ns/1ns
module core_memory_data_path_control_tb_top;
  import core_mem_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic               clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [3:0]         adr_i, sel_i, preamp_select_o, ps_or;
  logic [31:0]        dat_i, dat_o, q;
  logic               mem_req_i, read_mode_i, port_connect_gate_i;
  logic               clk_b_i, reset_early_i, wpar_i, rpar_o;
  logic               addr_here_o, req_release_o, core_rpar_i;
  logic               core_wpar_o, sense_strobe_o, airflow_fail_i;
  logic               voltage_fail_i, mem_disable_i, ancillary_present_i;
  logic               power_shutdown_o, predrive_disable_o, mem_status_o;
  logic               go, par_q, done, ovl, wp_seen, ss_seen, ah_seen;
  logic [ADDR_W-1:0]  addr_i, core_addr_o, ca_seen;
  logic [DATA_W-1:0]  wdata_i, rdata_o, core_rdata_i, core_wdata_o;
  logic [DATA_W-1:0]  data_q, wd_seen, rp_or;
  logic [2*PAIRS-1:0] drive_timing_o, dt_or;
  logic [1:0]         strobe_enable_o, se_or;
  int                 mismatches, tests_run;

  core_memory_data_path_control dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .mem_req_i, .addr_i, .read_mode_i,
    .port_connect_gate_i, .clk_b_i, .reset_early_i, .wdata_i, .wpar_i,
    .rdata_o, .rpar_o, .addr_here_o, .req_release_o, .core_rdata_i,
    .core_rpar_i, .core_addr_o, .core_wdata_o, .core_wpar_o,
    .drive_timing_o, .strobe_enable_o, .preamp_select_o,
    .sense_strobe_o, .airflow_fail_i, .voltage_fail_i, .mem_disable_i,
    .ancillary_present_i, .power_shutdown_o, .predrive_disable_o,
    .mem_status_o);
  port_user_model user (.clk_i, .rst_i, .go_i(go), .data_i(data_q),
    .par_i(par_q), .addr_here_i(addr_here_o), .release_i(req_release_o),
    .mem_req_o(mem_req_i), .clk_b_o(clk_b_i), .wdata_o(wdata_i),
    .wpar_o(wpar_i), .done_o(done));
  core_array_model cores (.clk_i, .core_addr_i(core_addr_o),
    .core_wdata_i(core_wdata_o), .core_wpar_i(core_wpar_o),
    .drive_timing_i(drive_timing_o), .strobe_enable_i(strobe_enable_o),
    .sense_strobe_i(sense_strobe_o), .core_rdata_o(core_rdata_i),
    .core_rpar_o(core_rpar_i));

  // Free-running 100 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Records what the memory side showed during a cycle.
  always @(negedge clk_i) begin
    dt_or   |= drive_timing_o;
    se_or   |= strobe_enable_o;
    ps_or   |= preamp_select_o;
    ss_seen |= sense_strobe_o;
    ah_seen |= addr_here_o;
    for (int k = 0; k < PAIRS; k++) begin
      ovl |= drive_timing_o[2*k] & drive_timing_o[2*k+1];
    end
    if (|drive_timing_o) begin
      ca_seen = core_addr_o;
    end
    if (|(drive_timing_o & 12'haaa)) begin
      wd_seen = core_wdata_o;
      wp_seen = core_wpar_o;
    end
    if (|(drive_timing_o & 12'h555)) begin
      rp_or |= core_wdata_o;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic bus cycle; read data lands in q.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // One port user request; ok says whether it must complete.
  task automatic run(input logic m, input logic [13:0] a,
                     input logic [15:0] d, input logic p, ok);
    int n;
    @(posedge clk_i);
    read_mode_i <= m;
    addr_i <= a;
    data_q <= d;
    par_q <= p;
    go <= 1'b1;
    {dt_or, se_or, ps_or, ovl, ss_seen, ah_seen, rp_or} = '0;
    wd_seen = 16'hffff;
    wp_seen = 1'b1;
    ca_seen = '0;
    for (n = 0; n < 100 && done !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    if (ok && done !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, read_mode_i, port_connect_gate_i, ancillary_present_i} = '1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, addr_i, go} = '0;
    {reset_early_i, airflow_fail_i, voltage_fail_i} = '0;
    {mem_disable_i, data_q, par_q, mismatches, tests_run} = '0;
    repeat (8) @(posedge clk_i);
    chk("predrive in reset", 32'h1, 32'(predrive_disable_o));
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, '0);
    chk("ctrl reset", CTRL_RST, q);
    wb(1'b1, 4'h2, 32'hffff_ffff);
    wb(1'b0, 4'h2, '0);
    chk("unmapped read", 32'h0, q);
    run(1'b1, 14'h0001, 16'h0000, 1'b0, 1'b1);
    chk("read word", 32'ha5c3, 32'(rdata_o));
    chk("read parity", 32'h1, 32'(rpar_o));
    chk("restore word", 32'ha5c3, 32'(wd_seen));
    chk("restore parity", 32'h1, 32'(wp_seen));
    chk("held address", 32'h1, 32'(ca_seen));
    chk("drive lines", 32'hccc, 32'(dt_or));
    chk("pair overlap", 32'h0, 32'(ovl));
    chk("strobe enables", 32'h3, 32'(se_or));
    chk("preamp select", 32'h2, 32'(ps_or));
    chk("sense strobe", 32'h1, 32'(ss_seen));
    chk("address here", 32'h1, 32'(ah_seen));
    wb(1'b0, INFO_OFS, '0);
    chk("info word", 32'h1a5c3, q);
    run(1'b0, 14'h0006, 16'h3c5a, 1'b0, 1'b1);
    chk("read pass blocked", 32'h0, 32'(rp_or));
    chk("new word", 32'h3c5a, 32'(wd_seen));
    chk("new parity", 32'h0, 32'(wp_seen));
    chk("user word held", 32'h3c5a, 32'(rdata_o));
    chk("drive lines", 32'hf30, 32'(dt_or));
    run(1'b1, 14'h0006, 16'hffff, 1'b1, 1'b1);
    chk("read back word", 32'h3c5a, 32'(rdata_o));
    chk("read back parity", 32'h0, 32'(rpar_o));
    @(posedge clk_i);
    port_connect_gate_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("cleared word", 32'h0, 32'(rdata_o));
    run(1'b0, 14'h0009, 16'hffff, 1'b1, 1'b1);
    chk("gated word", 32'h0, 32'(wd_seen));
    chk("gated parity", 32'h0, 32'(wp_seen));
    port_connect_gate_i <= 1'b1;
    wb(1'b0, COUNT_OFS, '0);
    chk("cycle count", 32'h4, q);
    // Each cause in turn must keep a request from starting.
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, CTRL_OFS, (c == 0) ? 32'h0 : CTRL_RST);
      voltage_fail_i <= (c == 1);
      ancillary_present_i <= (c != 2);
      reset_early_i <= (c == 3);
      run(1'b1, 14'h0003, 16'h0000, 1'b0, 1'b0);
      chk("refused", 32'h0, 32'(ah_seen));
      chk("no drive", 32'h0, 32'(dt_or));
    end
    ancillary_present_i <= 1'b1;
    reset_early_i <= 1'b0;
    // Every combination of the monitor and disable inputs.
    for (int i = 0; i < 8; i++) begin
      {mem_disable_i, airflow_fail_i, voltage_fail_i} <= 3'(i);
      repeat (3) @(posedge clk_i);
      chk("shutdown", 32'(i[1] & ~i[2]), 32'(power_shutdown_o));
      chk("predrive", 32'(|i[2:0]), 32'(predrive_disable_o));
      chk("status", 32'(i[1] & i[0]), 32'(mem_status_o));
    end
    give_verdict();
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule // core_memory_data_path_control_tb_top
